// >>> logic/scpm_level_decode.sv
// resistor level code to thermometer port mask
`timescale 1ns/1ns
module scpm_level_decode
    import scpm_pkg::*;
(
    input wire logic [2:0] i_level,
    output logic [PORT_COUNT-1:0] o_mask,
    output logic o_valid
);
    // map six resistor settings onto port masks starting at port 1
    always_comb begin
        o_valid = 1'b1;
        case (i_level)
            LVL_200K_DN: o_mask = 6'h00;
            LVL_200K_UP: o_mask = 6'h01;
            LVL_10K_DN: o_mask = 6'h03;
            LVL_10K_UP: o_mask = 6'h07;
            LVL_10R_DN: o_mask = 6'h0f;
            LVL_10R_UP: o_mask = 6'h3f;
            default: begin
                // unknown level: treat as weakest setting
                o_mask = 6'h00;
                o_valid = 1'b0;
            end
        endcase
    end
endmodule : scpm_level_decode

// >>> logic/scpm_strap_map.sv
// strap capture, default configuration and pin function map
`timescale 1ns/1ns
module scpm_strap_map
    import scpm_pkg::*;
#(
    parameter int unsigned NPORT = PORT_COUNT
) (
    input wire logic i_clk,
    input wire logic i_srst,
    // power-on or external reset still asserted
    input wire logic i_chip_rst,
    // straps as seen on the pins
    input wire logic [NPORT-1:0] i_port_dplus_disable_strap,
    input wire logic [NPORT-1:0] i_port_dminus_disable_strap,
    input wire logic [2:0] i_fixed_port_count_strap,
    input wire logic [2:0] i_charging_port_count_strap,
    input wire logic [1:0] i_mode_strap,
    // hub state
    input wire logic i_configuration_stage,
    input wire logic i_enumerated,
    // pin mux override write
    input wire logic i_ovr_valid,
    input wire scpm_src_t i_ovr_src,
    input wire logic [4:0] i_ovr_pin,
    input wire logic [FUNC_W-1:0] i_ovr_func,
    input wire logic i_ovr_clear,
    output logic o_ovr_accept,
    output logic o_ovr_reject,
    // decoded defaults
    output logic o_straps_valid,
    output logic [NPORT-1:0] o_port_hs_disable,
    output logic [NPORT-1:0] o_port_ss_disable,
    output logic [NPORT-1:0] o_port_fixed,
    output logic [NPORT-1:0] o_port_charging,
    output logic o_mode_two,
    output logic o_mode_reserved,
    output logic o_level_error,
    // flattened functions, pin 3 in the low field
    output logic [PIN_COUNT*FUNC_W-1:0] o_pin_func
);

    ////////////////////////////////////////////////////////////////////
    // strap capture
    logic [NPORT-1:0] dp_r; // captured plus-line straps
    logic [NPORT-1:0] dm_r; // captured minus-line straps
    logic [2:0] fixed_r; // captured fixed port level
    logic [2:0] chg_r; // captured charging level
    logic [1:0] mode_r; // captured mode straps
    logic rst_seen_r; // chip reset held last cycle
    logic valid_r; // straps have been captured
    logic capture; // reset release edge

    assign capture = rst_seen_r && !i_chip_rst;

    // track chip reset to find its release
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_seen_r <= 1'b1;
        end else begin
            rst_seen_r <= i_chip_rst;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dp_r <= '0;
            dm_r <= '0;
            fixed_r <= LVL_200K_DN;
            chg_r <= LVL_200K_DN;
            mode_r <= MODE_ONE;
            valid_r <= 1'b0;
        end else if (i_chip_rst) begin
            // captured values kept, only the valid flag cleared while reset is held
            valid_r <= 1'b0;
        end else if (capture) begin
            dp_r <= i_port_dplus_disable_strap;
            dm_r <= i_port_dminus_disable_strap;
            fixed_r <= i_fixed_port_count_strap;
            chg_r <= i_charging_port_count_strap;
            mode_r <= i_mode_strap;
            valid_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port disable decode
    logic [NPORT-1:0] hs_dis; // both lines high

    assign hs_dis = dp_r & dm_r;

    // registered disable outputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_port_hs_disable <= '0;
            o_port_ss_disable <= '0;
        end else begin
            o_port_hs_disable <= hs_dis;
            o_port_ss_disable <= hs_dis;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // level strap decode
    logic [PORT_COUNT-1:0] fixed_mask; // fixed port mask
    logic [PORT_COUNT-1:0] chg_mask; // charging port mask
    logic fixed_ok; // fixed level legal
    logic chg_ok; // charging level legal

    scpm_level_decode u_fixed_dec (
        .i_level(fixed_r),
        .o_mask(fixed_mask),
        .o_valid(fixed_ok)
    );

    scpm_level_decode u_chg_dec (
        .i_level(chg_r),
        .o_mask(chg_mask),
        .o_valid(chg_ok)
    );

    // registered level outputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_port_fixed <= '0;
            o_port_charging <= '0;
            o_level_error <= 1'b0;
        end else begin
            o_port_fixed <= fixed_mask[NPORT-1:0];
            o_port_charging <= chg_mask[NPORT-1:0];
            o_level_error <= valid_r && !(fixed_ok && chg_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode select
    logic mode_two; // second assignment chosen

    assign mode_two = (mode_r == MODE_TWO);

    // registered mode flags
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_mode_two <= 1'b0;
            o_mode_reserved <= 1'b0;
            o_straps_valid <= 1'b0;
        end else begin
            o_mode_two <= mode_two;
            // reserved pairs fall back to assignment one
            o_mode_reserved <= valid_r && (mode_r != MODE_ONE)
                && (mode_r != MODE_TWO);
            o_straps_valid <= valid_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // default function table
    // default function for pin index p (3..31)
    function automatic logic [FUNC_W-1:0] dflt_func(
        input logic [4:0] p,
        input logic two
    );
        logic [FUNC_W-1:0] f;
        f = FN_UNUSED;
        case (p)
            5'h03: f = FN_CABLE_SUPPLY_B;
            5'h04: f = FN_CABLE_SUPPLY_A;
            5'h05: f = FN_BUS_DISCHARGE;
            5'h06: f = FN_GPIO_70;
            5'h07: f = two ? FN_MIC_DETECT : FN_GPIO_71;
            5'h08: f = FN_GPIO_72;
            5'h09: f = FN_GPIO_73;
            5'h0a: f = two ? FN_AUDIO_DIN : FN_P2_SS_CTRL;
            5'h0b: f = two ? FN_AUDIO_MCLK : FN_P3_SS_CTRL;
            5'h0c: f = FN_P4_SS_CTRL;
            5'h0d: f = FN_P4_CTRL;
            5'h0e: f = FN_P3_CTRL;
            5'h0f: f = FN_P2_CTRL;
            5'h10: f = FN_P5_CTRL;
            5'h11: f = FN_P1_CTRL;
            5'h12: f = FN_COMPANION_IRQ;
            5'h13: f = two ? FN_AUDIO_DOUT : FN_UNUSED;
            5'h14: f = FN_FLASH_SELECT;
            5'h15: f = FN_FLASH_CLOCK;
            5'h16: f = FN_FLASH_D0;
            5'h17: f = FN_FLASH_D1;
            5'h18: f = FN_FLASH_D2;
            5'h19: f = FN_FLASH_D3;
            5'h1a: f = two ? FN_AUDIO_BCLK : FN_TGT_SER_CLK;
            5'h1b: f = two ? FN_P6_CTRL : FN_TGT_SER_LINE;
            5'h1c: f = two ? FN_AUDIO_WSEL : FN_P6_CTRL;
            5'h1d: f = FN_GPIO_93;
            5'h1e: f = FN_CTL_SER_CLK;
            5'h1f: f = FN_CTL_SER_DATA;
            default: f = FN_UNUSED;
        endcase
        return f;
    endfunction : dflt_func

    ////////////////////////////////////////////////////////////////////
    // override gate
    logic pin_ok; // pin index in range
    logic src_ok; // source allowed now

    assign pin_ok = (i_ovr_pin >= 5'(PIN_LOW))
        && (i_ovr_pin <= 5'(PIN_HIGH));

    always_comb begin
        case (i_ovr_src)
            SRC_CFG_STAGE: src_ok = i_configuration_stage;
            SRC_OTP: src_ok = 1'b1;
            SRC_TARGET_SER: src_ok = i_enumerated;
            SRC_FEATURE_CTL: src_ok = i_enumerated;
            default: src_ok = 1'b0;
        endcase
    end

    // combinational handshake answers
    assign o_ovr_accept = i_ovr_valid && valid_r && pin_ok && src_ok;
    assign o_ovr_reject = i_ovr_valid && !o_ovr_accept;

    ////////////////////////////////////////////////////////////////////
    // per pin override storage and output
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            logic ovr_en_r; // override active
            logic [FUNC_W-1:0] ovr_fn_r; // override function
            logic [FUNC_W-1:0] func_r; // function shown on this pin
            logic hit; // write aimed at this pin
            assign hit = o_ovr_accept && (i_ovr_pin == 5'(g + PIN_LOW));

            always_ff @(posedge i_clk) begin
                if (i_srst || i_chip_rst) begin
                    ovr_en_r <= 1'b0;
                    ovr_fn_r <= FN_UNUSED;
                end else if (hit) begin
                    ovr_en_r <= !i_ovr_clear;
                    ovr_fn_r <= i_ovr_func;
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    func_r <= FN_UNUSED;
                end else if (ovr_en_r) begin
                    func_r <= ovr_fn_r;
                end else begin
                    func_r <= dflt_func(5'(g + PIN_LOW), mode_two);
                end
            end

            // one driver per field of the flattened output
            assign o_pin_func[g*FUNC_W +: FUNC_W] = func_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // checks
    // both straps
    a_port_disable_pair: assert property (@(posedge i_clk) disable iff
        (i_srst) o_port_hs_disable == $past(dp_r & dm_r))
        else $error("port disable not from both straps");

    a_ss_follows_hs: assert property (@(posedge i_clk) disable iff
        (i_srst) o_port_ss_disable == $past(dp_r & dm_r))
        else $error("superspeed disable differs");

    a_fixed_thermo: assert property (@(posedge i_clk) disable iff
        (i_srst) ((o_port_fixed + 6'h01) & o_port_fixed) == '0)
        else $error("fixed ports not contiguous from port 1");

    a_chg_level_map: assert property (@(posedge i_clk) disable iff
        (i_srst) (chg_r == LVL_10R_UP) |=> o_port_charging == 6'h3f)
        else $error("charging all ports not decoded");

    a_runtime_gate: assert property (@(posedge i_clk) disable iff
        (i_srst) (i_ovr_valid && i_ovr_src == SRC_TARGET_SER
        && !i_enumerated) |-> o_ovr_reject)
        else $error("runtime override before enumeration");

    a_capture_edge: assert property (@(posedge i_clk) disable iff
        (i_srst) capture |=> (mode_r == $past(i_mode_strap)))
        else $error("mode strap not captured at release");

    a_hold_straps: assert property (@(posedge i_clk) disable iff
        (i_srst) (!i_chip_rst && !capture) |=> $stable(dp_r))
        else $error("captured strap changed");

    a_pin7_mode: assert property (@(posedge i_clk) disable iff
        (i_srst) (mode_two && !g_pin[4].ovr_en_r) |=>
        o_pin_func[4*FUNC_W +: FUNC_W] == FN_MIC_DETECT)
        else $error("pin 7 default wrong in mode two");

    c_capture: cover property (@(posedge i_clk) capture);
    c_mode_two: cover property (@(posedge i_clk) valid_r && mode_two);
    c_ovr_accept: cover property (@(posedge i_clk) o_ovr_accept);
    c_port_off: cover property (@(posedge i_clk) |o_port_hs_disable);

endmodule : scpm_strap_map

// >>> shared/scpm_pkg.sv
// constants for the strap capture and pin function map block
package scpm_pkg;
    // number of downstream ports
    localparam int unsigned PORT_COUNT = 6;
    // programmable function pins run from this index upward
    localparam int unsigned PIN_LOW = 3;
    localparam int unsigned PIN_HIGH = 31;
    localparam int unsigned PIN_COUNT = PIN_HIGH - PIN_LOW + 1;
    // function code width
    localparam int unsigned FUNC_W = 6;
    // resistor level codes from the analog strap sensor
    localparam logic [2:0] LVL_200K_DN = 3'h0;
    localparam logic [2:0] LVL_200K_UP = 3'h1;
    localparam logic [2:0] LVL_10K_DN = 3'h2;
    localparam logic [2:0] LVL_10K_UP = 3'h3;
    localparam logic [2:0] LVL_10R_DN = 3'h4;
    localparam logic [2:0] LVL_10R_UP = 3'h5;
    // mode strap pairs: {upper, lower}, 1 means pull-up
    localparam logic [1:0] MODE_ONE = 2'h0;
    localparam logic [1:0] MODE_TWO = 2'h1;
    // function codes
    localparam logic [5:0] FN_UNUSED = 6'h00;
    localparam logic [5:0] FN_CABLE_SUPPLY_B = 6'h01;
    localparam logic [5:0] FN_CABLE_SUPPLY_A = 6'h02;
    localparam logic [5:0] FN_BUS_DISCHARGE = 6'h03;
    localparam logic [5:0] FN_GPIO_70 = 6'h04;
    localparam logic [5:0] FN_GPIO_71 = 6'h05;
    localparam logic [5:0] FN_GPIO_72 = 6'h06;
    localparam logic [5:0] FN_GPIO_73 = 6'h07;
    localparam logic [5:0] FN_P2_SS_CTRL = 6'h08;
    localparam logic [5:0] FN_P3_SS_CTRL = 6'h09;
    localparam logic [5:0] FN_P4_SS_CTRL = 6'h0a;
    localparam logic [5:0] FN_P4_CTRL = 6'h0b;
    localparam logic [5:0] FN_P3_CTRL = 6'h0c;
    localparam logic [5:0] FN_P2_CTRL = 6'h0d;
    localparam logic [5:0] FN_P5_CTRL = 6'h0e;
    localparam logic [5:0] FN_P1_CTRL = 6'h0f;
    localparam logic [5:0] FN_COMPANION_IRQ = 6'h10;
    localparam logic [5:0] FN_FLASH_SELECT = 6'h11;
    localparam logic [5:0] FN_FLASH_CLOCK = 6'h12;
    localparam logic [5:0] FN_FLASH_D0 = 6'h13;
    localparam logic [5:0] FN_FLASH_D1 = 6'h14;
    localparam logic [5:0] FN_FLASH_D2 = 6'h15;
    localparam logic [5:0] FN_FLASH_D3 = 6'h16;
    localparam logic [5:0] FN_TGT_SER_CLK = 6'h17;
    localparam logic [5:0] FN_TGT_SER_LINE = 6'h18;
    localparam logic [5:0] FN_P6_CTRL = 6'h19;
    localparam logic [5:0] FN_GPIO_93 = 6'h1a;
    localparam logic [5:0] FN_CTL_SER_CLK = 6'h1b;
    localparam logic [5:0] FN_CTL_SER_DATA = 6'h1c;
    localparam logic [5:0] FN_MIC_DETECT = 6'h1d;
    localparam logic [5:0] FN_AUDIO_DIN = 6'h1e;
    localparam logic [5:0] FN_AUDIO_MCLK = 6'h1f;
    localparam logic [5:0] FN_AUDIO_DOUT = 6'h20;
    localparam logic [5:0] FN_AUDIO_BCLK = 6'h21;
    localparam logic [5:0] FN_AUDIO_WSEL = 6'h22;
    // override sources
    typedef enum logic [1:0] {
        SRC_CFG_STAGE,
        SRC_OTP,
        SRC_TARGET_SER,
        SRC_FEATURE_CTL
    } scpm_src_t;
endpackage : scpm_pkg

// >>> tb/scpm_board_model.sv
// board strap resistors and the circuits sharing the strap pins
`timescale 1ns/1ns
module scpm_board_model
    import scpm_pkg::*;
#(
    parameter int unsigned NPORT = PORT_COUNT
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_chip_rst,
    // resistor fit chosen by the bench
    input wire logic [NPORT-1:0] i_cfg_dp,
    input wire logic [NPORT-1:0] i_cfg_dm,
    input wire logic [2:0] i_cfg_fixed,
    input wire logic [2:0] i_cfg_chg,
    input wire logic [1:0] i_cfg_mode,
    // levels seen at the strap pins
    output logic [NPORT-1:0] o_dp,
    output logic [NPORT-1:0] o_dm,
    output logic [2:0] o_fixed,
    output logic [2:0] o_chg,
    output logic [1:0] o_mode
);
    ////////////////////////////////////////////////////////////////////////
    // edges since reset release, saturating
    logic [1:0] cnt_r;
    // straps valid while reset held and two edges after
    logic hold;
    // third mode strap sits on its 200k pull-down, never sensed
    // board ties third strap
    localparam logic MODE3_LEVEL = 1'b0;

    assign hold = i_srst || i_chip_rst || (cnt_r < 2'h2);

    // count edges after reset release
    always_ff @(posedge i_clk) begin
        if (i_srst || i_chip_rst) begin
            cnt_r <= 2'h0;
        end else if (cnt_r != 2'h3) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    // resistors during capture, pin traffic afterwards
    // board strap levels
    always_ff @(posedge i_clk) begin
        if (hold) begin
            o_dp <= i_cfg_dp;
            o_dm <= i_cfg_dm;
            o_fixed <= i_cfg_fixed;
            o_chg <= i_cfg_chg;
            o_mode <= i_cfg_mode | {MODE3_LEVEL, 1'b0};
        end else begin
            // shared pins now carry traffic that changes every cycle
            o_dp <= ~o_dp;
            o_dm <= ~o_dm;
            o_fixed <= ~o_fixed;
            o_chg <= ~o_chg;
            o_mode <= ~o_mode;
        end
    end
endmodule : scpm_board_model

// >>> tb/tb.sv
// self-checking bench for the strap capture and pin function map
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    import scpm_pkg::*;
    localparam int NP = PORT_COUNT;
    logic clk, srst, chip, cfgst, enm, ovld, oclr, acc, rej, sval;
    logic mtwo, mres, lerr;
    scpm_src_t osrc;
    logic [4:0] opin;
    logic [5:0] ofn;
    logic [NP-1:0] dp, dm, cdp, cdm, hs, ss, fx, ch;
    logic [2:0] fxs, chs, cfx, cch;
    logic [1:0] mds, cmd;
    logic [PIN_COUNT*FUNC_W-1:0] pfn;
    int errors, num_checks, ovr[32];
    bit cap;

    scpm_board_model #(.NPORT(NP)) scpm_board_model_inst (.i_clk(clk),
        .i_srst(srst), .i_chip_rst(chip), .i_cfg_dp(cdp), .i_cfg_dm(cdm),
        .i_cfg_fixed(cfx), .i_cfg_chg(cch), .i_cfg_mode(cmd), .o_dp(dp),
        .o_dm(dm), .o_fixed(fxs), .o_chg(chs), .o_mode(mds));
    scpm_strap_map #(.NPORT(NP)) scpm_strap_map_inst (.i_clk(clk),
        .i_srst(srst), .i_chip_rst(chip), .i_port_dplus_disable_strap(dp),
        .i_port_dminus_disable_strap(dm), .i_fixed_port_count_strap(fxs),
        .i_charging_port_count_strap(chs), .i_mode_strap(mds),
        .i_configuration_stage(cfgst), .i_enumerated(enm),
        .i_ovr_valid(ovld), .i_ovr_src(osrc), .i_ovr_pin(opin),
        .i_ovr_func(ofn), .i_ovr_clear(oclr), .o_ovr_accept(acc),
        .o_ovr_reject(rej), .o_straps_valid(sval), .o_port_hs_disable(hs),
        .o_port_ss_disable(ss), .o_port_fixed(fx), .o_port_charging(ch),
        .o_mode_two(mtwo), .o_mode_reserved(mres), .o_level_error(lerr),
        .o_pin_func(pfn));

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // thermometer mask of a resistor level code, 0 for unknown codes
    function automatic logic [NP-1:0] therm(logic [2:0] lvl);
        int n;
        n = (lvl == 3'h5) ? 6 : int'(lvl);
        if (lvl > 3'h5) begin
            n = 0;
        end
        return NP'((1 << n) - 1);
    endfunction : therm

    // strap-selected default function of a pin
    function automatic logic [5:0] def_fn(int p, bit two);
        if (two) begin
            case (p)
                7: return FN_MIC_DETECT;
                10: return FN_AUDIO_DIN;
                11: return FN_AUDIO_MCLK;
                19: return FN_AUDIO_DOUT;
                26: return FN_AUDIO_BCLK;
                27: return FN_P6_CTRL;
                28: return FN_AUDIO_WSEL;
                default: ;
            endcase
        end
        // assignment one codes follow pin order, pin 19 has none
        if (p == 19) begin
            return FN_UNUSED;
        end
        return 6'(p < 19 ? p - 2 : p - 3);
    endfunction : def_fn

    // compare every decoded default and every pin function
    task automatic check_all();
        logic [5:0] e;
        bit two;
        two = (cmd == MODE_TWO);
        `CHK(sval, 1'b1)
        `CHK(hs, cdp & cdm)
        `CHK(ss, cdp & cdm)
        `CHK(fx, therm(cfx))
        `CHK(ch, therm(cch))
        `CHK(mtwo, two)
        `CHK(mres, cmd[1])
        `CHK(lerr, (cfx > 3'h5) || (cch > 3'h5))
        for (int p = 3; p <= 31; p++) begin
            e = (ovr[p] < 0) ? def_fn(p, two) : 6'(ovr[p]);
            `CHK(pfn[(p-3)*FUNC_W +: FUNC_W], e)
        end
    endtask : check_all

    // back-to-back random override writes, then settle
    task automatic burst(int n);
        bit a;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #5;
            ovld = 1'b1;
            osrc = scpm_src_t'($urandom_range(3, 0));
            opin = 5'($urandom_range(31, 0));
            ofn = 6'($urandom_range(34, 0));
            oclr = ($urandom_range(3, 0) == 0);
            cfgst = 1'($urandom_range(1, 0));
            enm = 1'($urandom_range(1, 0));
            #1;
            a = cap && opin >= 5'h3 && (osrc == SRC_OTP ||
                (osrc == SRC_CFG_STAGE && cfgst) || (osrc > SRC_OTP && enm));
            `CHK(acc, a)
            `CHK(rej, !a)
            if (a) begin
                ovr[opin] = oclr ? -1 : int'(ofn);
            end
        end
        @(posedge clk);
        #5;
        ovld = 1'b0;
        repeat (2) @(posedge clk);
        #5;
    endtask : burst

    // verdict and end of run
    task automatic complete_run();
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // watchdog well past the expected run length
    initial begin
        #400000;
        errors++;
        complete_run();
    end

    // main sequence: one capture round per reset
    initial begin
        {srst, chip, cfgst, enm, ovld, oclr} = 6'h20;
        osrc = SRC_CFG_STAGE;
        opin = 5'h00;
        ofn = 6'h00;
        errors = 0;
        num_checks = 0;
        void'($urandom(77));
        for (int r = 0; r < 24; r++) begin
            cdp = NP'($urandom);
            cdm = NP'($urandom) | cdp;
            cdm = (r % 3 == 0) ? cdm : NP'($urandom);
            cfx = 3'(r % 8);
            cch = 3'((r + 3) % 8);
            cmd = 2'(r % 4);
            foreach (ovr[k]) ovr[k] = -1;
            cap = 0;
            if (r == 0 || r == 12) begin
                // synchronous reset also triggers a capture
                srst = 1'b1;
                repeat (6) @(posedge clk);
                #5;
                srst = 1'b0;
            end else begin
                chip = 1'b1;
                burst(1);
                `CHK(sval, 1'b0)
                chip = 1'b0;
            end
            repeat (4) @(posedge clk);
            #5;
            cap = 1;
            check_all();
            burst(10);
            check_all();
            burst(12);
            check_all();
        end
        complete_run();
    end
endmodule : tb
